// ---- core/dphs_pkg.sv ----
// constants shared by the dual port handshake controller
`default_nettype none
package dphs_pkg;
  // ---------------------------------------------------------------
  // port modes, as carried in bits 7:6 of a mode word
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_OUT = 2'h0;
  localparam logic [1:0] MODE_IN = 2'h1;
  localparam logic [1:0] MODE_BIDIR = 2'h2;
  localparam logic [1:0] MODE_CTL = 2'h3;
  localparam logic [1:0] MODE_RST = MODE_IN;
  // ---------------------------------------------------------------
  // control word layout
  // ---------------------------------------------------------------
  localparam int CW_FLAG_BIT = 0;
  localparam int CW_MODE_HI = 7;
  localparam int CW_MODE_LO = 6;
  localparam int CW_IE_BIT = 7;
  localparam int CW_AND_BIT = 6;
  localparam int CW_LVL_BIT = 5;
  localparam int CW_MASKNEXT_BIT = 4;
  localparam logic [3:0] CW_MODE_TAG = 4'hf;
  localparam logic [3:0] CW_INTCTL_TAG = 4'h7;
  // ---------------------------------------------------------------
  // reset values, and the fixed low bit of an interrupt vector
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic VEC_LSB = 1'h0;
  // ---------------------------------------------------------------
  // return-from-interrupt opcode pair seen on fetch cycles
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_PREFIX = 8'hed;
  localparam logic [7:0] OPC_RETURN = 8'h4d;
  // ---------------------------------------------------------------
  // pin synchroniser vector layout
  // ---------------------------------------------------------------
  localparam int SY_CE = 0;
  localparam int SY_IO_REQUEST_N = 1;
  localparam int SY_RD = 2;
  localparam int SY_M1 = 3;
  localparam int SY_BSEL = 4;
  localparam int SY_CD = 5;
  localparam int SY_IEI = 6;
  localparam int SY_STBA = 7;
  localparam int SY_STBB = 8;
  localparam int SY_HD = 9;
  localparam int SY_PA = 17;
  localparam int SY_PB = 25;
  localparam int SY_W = 33;
  // idle levels: strobes, control select and active-low bus controls high
  localparam logic [32:0] SY_RST = 33'h0000001af;
endpackage
`default_nettype wire

// ---- core/dphs_sync.sv ----
// three-flop pin synchroniser with agreement filter
`default_nettype none
module dphs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ---------------------------------------------------------------
  // flop chain; a bit changes once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
          q[i] <= s3_reg[i];
      end
    end
  end
endmodule // dphs_sync
`default_nettype wire

// ---- core/dphs_top.sv ----
// dual 8-bit parallel port controller with handshake and vectored interrupt
`default_nettype none
module dphs_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE_N,
  input wire logic IO_REQUEST_N,
  input wire logic RD_N,
  input wire logic FIRST_CYCLE_N,
  input wire logic PORT_SEL,
  input wire logic CTRL_SEL,
  input wire logic CHAIN_ENABLE_IN,
  input wire logic PORT_A_STROBE_N,
  input wire logic PORT_B_STROBE_N,
  input wire logic [7:0] HOST_DATA_BUS_I,
  input wire logic [7:0] PORT_A_LINES_I,
  input wire logic [7:0] PORT_B_LINES_I,
  output logic [7:0] HOST_DATA_BUS_O,
  output logic HOST_DATA_BUS_OE,
  output logic [7:0] PORT_A_LINES_O,
  output logic [7:0] PORT_A_LINES_OE,
  output logic [7:0] PORT_B_LINES_O,
  output logic [7:0] PORT_B_LINES_OE,
  output logic PORT_A_READY,
  output logic PORT_B_READY,
  output logic CHAIN_ENABLE_OUT,
  output logic INT_N_O,
  output logic INT_N_OE
);
  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic [dphs_pkg::SY_W-1:0] sy;
  logic ce, io_request_n, rd, m1, bsel, cd, chain_enable_in;
  logic [1:0] stb_n;
  logic [7:0] hd;
  logic [7:0] lines [2];

  dphs_sync #(
    .WIDTH(dphs_pkg::SY_W),
    .RST_VAL(dphs_pkg::SY_RST)
  ) u_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .d({PORT_B_LINES_I, PORT_A_LINES_I, HOST_DATA_BUS_I, PORT_B_STROBE_N,
        PORT_A_STROBE_N, CHAIN_ENABLE_IN, CTRL_SEL, PORT_SEL, FIRST_CYCLE_N,
        RD_N, IO_REQUEST_N, CE_N}),
    .q(sy)
  );

  // filtered pin levels, active-high inside except the strobes
  assign ce = ~sy[dphs_pkg::SY_CE];
  assign io_request_n = ~sy[dphs_pkg::SY_IO_REQUEST_N];
  assign rd = ~sy[dphs_pkg::SY_RD];
  assign m1 = ~sy[dphs_pkg::SY_M1];
  assign bsel = sy[dphs_pkg::SY_BSEL];
  assign cd = sy[dphs_pkg::SY_CD];
  assign chain_enable_in = sy[dphs_pkg::SY_IEI];
  assign stb_n = {sy[dphs_pkg::SY_STBB], sy[dphs_pkg::SY_STBA]};
  assign hd = sy[dphs_pkg::SY_HD +: 8];
  assign lines[0] = sy[dphs_pkg::SY_PA +: 8];
  assign lines[1] = sy[dphs_pkg::SY_PB +: 8];

  // ---------------------------------------------------------------
  // per-port state
  // ---------------------------------------------------------------
  logic [1:0] mode_reg [2];
  logic [7:0] out_reg [2];
  logic [7:0] in_reg [2];
  logic [7:0] dir_reg [2];
  logic [7:0] mask_reg [2];
  logic [6:0] vec_reg [2];
  logic [1:0] ie_reg, and_reg, lvl_reg, pend_reg, serv_reg;
  logic [1:0] exp_dir_reg, exp_mask_reg, out_rdy_reg, in_rdy_reg, hit_prev_reg;
  logic [1:0] stb_prev_reg;
  logic hold_rst_reg;

  // ---------------------------------------------------------------
  // host cycle tracking
  // ---------------------------------------------------------------
  logic rd_act, wr_act, iack, fetch;
  logic wr_prev_reg, rd_prev_reg, iack_prev_reg, fetch_prev_reg, m1_prev_reg;
  logic m1_io_reg, saw_prefix_reg, wr_cd_reg, wr_port_reg, rd_port_reg;
  logic [7:0] wr_data_reg, fetch_data_reg;
  logic wr_done, rd_done, m1_rst_evt, reti_evt, iack_rise;

  assign rd_act = ce & rd & io_request_n & ~m1;
  assign wr_act = ce & io_request_n & ~rd & ~m1;
  assign iack = io_request_n & m1;
  assign fetch = m1 & rd & ~io_request_n;
  assign wr_done = wr_prev_reg & ~wr_act;
  assign rd_done = rd_prev_reg & ~rd_act;
  assign iack_rise = iack & ~iack_prev_reg;
  assign m1_rst_evt = m1_prev_reg & ~m1 & ~m1_io_reg & ~rd & ~io_request_n;
  assign reti_evt = fetch_prev_reg & ~fetch & saw_prefix_reg
                    & (fetch_data_reg == dphs_pkg::OPC_RETURN);

  // cycle edge history and latched address / data
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
      iack_prev_reg <= 1'b0;
      fetch_prev_reg <= 1'b0;
      m1_prev_reg <= 1'b0;
      m1_io_reg <= 1'b0;
      wr_cd_reg <= 1'b0;
      wr_port_reg <= 1'b0;
      rd_port_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      fetch_data_reg <= 8'h00;
      saw_prefix_reg <= 1'b0;
    end
    else
    begin
      wr_prev_reg <= wr_act;
      rd_prev_reg <= rd_act;
      iack_prev_reg <= iack;
      fetch_prev_reg <= fetch;
      m1_prev_reg <= m1;
      m1_io_reg <= m1 & (m1_io_reg | rd | io_request_n);
      if (wr_act)
      begin
        wr_cd_reg <= cd;
        wr_port_reg <= bsel;
        wr_data_reg <= hd;
      end
      if (rd_act)
        rd_port_reg <= bsel;
      if (fetch)
        fetch_data_reg <= hd;
      if (fetch_prev_reg && !fetch)
        saw_prefix_reg <= (fetch_data_reg == dphs_pkg::OPC_PREFIX);
    end
  end

  // ---------------------------------------------------------------
  // strobe decode per port
  // ---------------------------------------------------------------
  logic a_bidir;
  logic [1:0] stb_rise, ack_rise, load_low, load_rise, hit, evt;

  // match test of unmasked input lines for control mode interrupts
  function automatic logic mon_hit(input logic [7:0] ln, input logic [7:0] dir,
                                   input logic [7:0] msk, input logic all_of,
                                   input logic lvl);
    logic [7:0] sel;
    logic [7:0] act;
    sel = dir & ~msk;
    act = ~(ln ^ {8{lvl}}) & sel;
    mon_hit = all_of ? ((sel != 8'h00) && (act == sel)) : (act != 8'h00);
  endfunction

  assign a_bidir = (mode_reg[0] == dphs_pkg::MODE_BIDIR);
  assign stb_rise = stb_n & ~stb_prev_reg;

  always_comb
  begin
    // control mode drops the strobe entirely
    ack_rise[0] = stb_rise[0] & ((mode_reg[0] == dphs_pkg::MODE_OUT) | a_bidir);
    ack_rise[1] = stb_rise[1] & (mode_reg[1] == dphs_pkg::MODE_OUT) & ~a_bidir;
    load_low[0] = ((mode_reg[0] == dphs_pkg::MODE_IN) & ~stb_n[0])
                  | (a_bidir & ~stb_n[1]);
    load_low[1] = (mode_reg[1] == dphs_pkg::MODE_IN) & ~stb_n[1] & ~a_bidir;
    load_rise[0] = ((mode_reg[0] == dphs_pkg::MODE_IN) & stb_rise[0])
                   | (a_bidir & stb_rise[1]);
    load_rise[1] = (mode_reg[1] == dphs_pkg::MODE_IN) & stb_rise[1] & ~a_bidir;
    for (int p = 0; p < 2; p++)
      hit[p] = (mode_reg[p] == dphs_pkg::MODE_CTL)
               & mon_hit(lines[p], dir_reg[p], mask_reg[p], and_reg[p], lvl_reg[p]);
    // bidirectional input transfers interrupt on port B's vector
    evt[0] = ack_rise[0] | ((mode_reg[0] == dphs_pkg::MODE_IN) & stb_rise[0])
             | (hit[0] & ~hit_prev_reg[0]);
    evt[1] = ack_rise[1] | load_rise[1] | (a_bidir & stb_rise[1])
             | (hit[1] & ~hit_prev_reg[1]);
  end

  // ---------------------------------------------------------------
  // internal reset state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      hold_rst_reg <= 1'b1;
    else if (m1_rst_evt)
      hold_rst_reg <= 1'b1;
    else if (wr_done && wr_cd_reg)
      hold_rst_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // control words, mode and data registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N || m1_rst_evt)
    begin
      for (int p = 0; p < 2; p++)
      begin
        mode_reg[p] <= dphs_pkg::MODE_RST;
        out_reg[p] <= dphs_pkg::OUT_RST;
        dir_reg[p] <= dphs_pkg::DIR_RST;
        mask_reg[p] <= dphs_pkg::MASK_RST;
      end
      ie_reg <= 2'h0;
      and_reg <= 2'h0;
      lvl_reg <= 2'h0;
      exp_dir_reg <= 2'h0;
      exp_mask_reg <= 2'h0;
    end
    else if (wr_done && wr_cd_reg)
    begin
      // control word to the addressed port
      if (exp_dir_reg[wr_port_reg])
      begin
        dir_reg[wr_port_reg] <= wr_data_reg;
        exp_dir_reg[wr_port_reg] <= 1'b0;
      end
      else if (exp_mask_reg[wr_port_reg])
      begin
        mask_reg[wr_port_reg] <= wr_data_reg;
        exp_mask_reg[wr_port_reg] <= 1'b0;
      end
      else if (wr_data_reg[3:0] == dphs_pkg::CW_MODE_TAG)
      begin
        // port B keeps its old mode when bidirectional is asked for
        if (!(wr_port_reg && wr_data_reg[dphs_pkg::CW_MODE_HI:dphs_pkg::CW_MODE_LO]
              == dphs_pkg::MODE_BIDIR))
          mode_reg[wr_port_reg] <= wr_data_reg[dphs_pkg::CW_MODE_HI:dphs_pkg::CW_MODE_LO];
        exp_dir_reg[wr_port_reg] <= (wr_data_reg[dphs_pkg::CW_MODE_HI:dphs_pkg::CW_MODE_LO]
                                     == dphs_pkg::MODE_CTL);
      end
      else if (wr_data_reg[3:0] == dphs_pkg::CW_INTCTL_TAG)
      begin
        ie_reg[wr_port_reg] <= wr_data_reg[dphs_pkg::CW_IE_BIT];
        and_reg[wr_port_reg] <= wr_data_reg[dphs_pkg::CW_AND_BIT];
        lvl_reg[wr_port_reg] <= wr_data_reg[dphs_pkg::CW_LVL_BIT];
        exp_mask_reg[wr_port_reg] <= wr_data_reg[dphs_pkg::CW_MASKNEXT_BIT];
      end
    end
    else if (wr_done && !hold_rst_reg)
      out_reg[wr_port_reg] <= wr_data_reg;
  end

  // vector registers survive every reset
  always_ff @(posedge CLK)
  begin
    if (wr_done && wr_cd_reg && !exp_dir_reg[wr_port_reg] && !exp_mask_reg[wr_port_reg]
        && !wr_data_reg[dphs_pkg::CW_FLAG_BIT])
      vec_reg[wr_port_reg] <= wr_data_reg[7:1];
  end

  // input registers: strobe capture, or live sampling in control mode
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      in_reg[0] <= 8'h00;
      in_reg[1] <= 8'h00;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (load_low[p])
          in_reg[p] <= lines[p];
        else if (mode_reg[p] == dphs_pkg::MODE_CTL && !rd_act)
          in_reg[p] <= lines[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // handshake flags, set wins over clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST_N || m1_rst_evt)
    begin
      out_rdy_reg <= 2'h0;
      in_rdy_reg <= 2'h0;
      stb_prev_reg <= 2'h3;
      hit_prev_reg <= 2'h0;
    end
    else
    begin
      stb_prev_reg <= stb_n;
      hit_prev_reg <= hit;
      for (int p = 0; p < 2; p++)
      begin
        if (wr_done && !wr_cd_reg && !hold_rst_reg && wr_port_reg == p[0])
          out_rdy_reg[p] <= 1'b1;
        else if (ack_rise[p])
          out_rdy_reg[p] <= 1'b0;
        if (rd_done && rd_port_reg == p[0] && !hold_rst_reg
            && (mode_reg[p] == dphs_pkg::MODE_IN || (p == 0 && a_bidir)))
          in_rdy_reg[p] <= 1'b1;
        else if (load_rise[p])
          in_rdy_reg[p] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt pending, service and daisy chain
  // ---------------------------------------------------------------
  logic [1:0] req;
  logic ack_port;

  assign req = pend_reg & ie_reg;
  assign ack_port = ~req[0];

  always_ff @(posedge CLK)
  begin
    if (!RST_N || m1_rst_evt)
    begin
      pend_reg <= 2'h0;
      serv_reg <= 2'h0;
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        if (evt[p] && !hold_rst_reg)
          pend_reg[p] <= 1'b1;
        else if (wr_done && wr_cd_reg && wr_port_reg == p[0] && !exp_dir_reg[p]
                 && !exp_mask_reg[p] && wr_data_reg[3:0] == dphs_pkg::CW_INTCTL_TAG
                 && wr_data_reg[dphs_pkg::CW_MASKNEXT_BIT])
          pend_reg[p] <= 1'b0;
        else if (iack_rise && chain_enable_in && serv_reg == 2'h0 && req != 2'h0 && ack_port == p[0])
          pend_reg[p] <= 1'b0;
      end
      if (iack_rise && chain_enable_in && serv_reg == 2'h0 && req != 2'h0)
        serv_reg[ack_port] <= 1'b1;
      else if (reti_evt && chain_enable_in)
        serv_reg <= serv_reg[0] ? {serv_reg[1], 1'b0} : 2'h0;
    end
  end

  // chain out and open-drain request
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      CHAIN_ENABLE_OUT <= 1'b0;
      INT_N_O <= 1'b0;
      INT_N_OE <= 1'b0;
    end
    else
    begin
      CHAIN_ENABLE_OUT <= chain_enable_in & (serv_reg == 2'h0);
      INT_N_O <= 1'b0;
      INT_N_OE <= chain_enable_in & (req != 2'h0) & (serv_reg == 2'h0) & ~hold_rst_reg;
    end
  end

  // ---------------------------------------------------------------
  // host data bus
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_val(input logic [1:0] md, input logic [7:0] o,
                                          input logic [7:0] i, input logic [7:0] dir);
    case (md)
      dphs_pkg::MODE_OUT: read_val = o;
      dphs_pkg::MODE_CTL: read_val = (dir & i) | (~dir & o);
      default: read_val = i;
    endcase
  endfunction

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      HOST_DATA_BUS_O <= 8'h00;
      HOST_DATA_BUS_OE <= 1'b0;
    end
    else if (iack_rise && chain_enable_in && serv_reg == 2'h0 && req != 2'h0)
    begin
      HOST_DATA_BUS_O <= {vec_reg[ack_port], dphs_pkg::VEC_LSB};
      HOST_DATA_BUS_OE <= 1'b1;
    end
    else if (rd_act)
    begin
      HOST_DATA_BUS_O <= read_val(mode_reg[bsel], out_reg[bsel], in_reg[bsel],
                                  dir_reg[bsel]);
      HOST_DATA_BUS_OE <= 1'b1;
    end
    else if (!iack)
      HOST_DATA_BUS_OE <= 1'b0;
  end

  // ---------------------------------------------------------------
  // port lines and ready outputs
  // ---------------------------------------------------------------
  function automatic logic [7:0] line_oe(input logic [1:0] md, input logic [7:0] dir,
                                         input logic stb_low);
    case (md)
      dphs_pkg::MODE_OUT: line_oe = 8'hff;
      dphs_pkg::MODE_BIDIR: line_oe = {8{stb_low}};
      dphs_pkg::MODE_CTL: line_oe = ~dir;
      default: line_oe = 8'h00;
    endcase
  endfunction

  always_ff @(posedge CLK)
  begin
    if (!RST_N || m1_rst_evt || hold_rst_reg)
    begin
      PORT_A_LINES_O <= 8'h00;
      PORT_A_LINES_OE <= 8'h00;
      PORT_B_LINES_O <= 8'h00;
      PORT_B_LINES_OE <= 8'h00;
      PORT_A_READY <= 1'b0;
      PORT_B_READY <= 1'b0;
    end
    else
    begin
      PORT_A_LINES_O <= out_reg[0];
      PORT_A_LINES_OE <= line_oe(mode_reg[0], dir_reg[0], ~stb_n[0]);
      PORT_B_LINES_O <= out_reg[1];
      PORT_B_LINES_OE <= line_oe(mode_reg[1], dir_reg[1], 1'b0);
      case (mode_reg[0])
        dphs_pkg::MODE_IN: PORT_A_READY <= in_rdy_reg[0];
        dphs_pkg::MODE_CTL: PORT_A_READY <= 1'b0;
        default: PORT_A_READY <= out_rdy_reg[0];
      endcase
      if (a_bidir)
        PORT_B_READY <= in_rdy_reg[0];
      else if (mode_reg[1] == dphs_pkg::MODE_OUT)
        PORT_B_READY <= out_rdy_reg[1];
      else if (mode_reg[1] == dphs_pkg::MODE_IN)
        PORT_B_READY <= in_rdy_reg[1];
      else
        PORT_B_READY <= 1'b0;
    end
  end
endmodule // dphs_top
`default_nettype wire

// ---- testbench/dphs_assertions.sv ----
// pin-level checks for the dual port handshake controller
`default_nettype none
module dphs_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE_N,
  input wire logic IO_REQUEST_N,
  input wire logic RD_N,
  input wire logic FIRST_CYCLE_N,
  input wire logic CHAIN_ENABLE_IN,
  input wire logic PORT_A_STROBE_N,
  input wire logic [7:0] HOST_DATA_BUS_O,
  input wire logic HOST_DATA_BUS_OE,
  input wire logic [7:0] PORT_A_LINES_OE,
  input wire logic PORT_A_READY,
  input wire logic PORT_B_READY,
  input wire logic CHAIN_ENABLE_OUT,
  input wire logic INT_N_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // relations between the pins
  // ------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_reset_quiet:
    assert property ($rose(RST_N) |-> !HOST_DATA_BUS_OE && !PORT_A_READY && !PORT_B_READY
      && PORT_A_LINES_OE == 8'h00) else $error("outputs active after reset");
  a_chain_block:
    assert property (!CHAIN_ENABLE_IN [*6] |-> !CHAIN_ENABLE_OUT) else $error("chain out high");
  a_read_drive:
    assert property ((!CE_N && !RD_N && !IO_REQUEST_N && FIRST_CYCLE_N) [*8] |-> HOST_DATA_BUS_OE)
      else $error("read not answered");
  a_idle_float:
    assert property (IO_REQUEST_N [*8] |-> !HOST_DATA_BUS_OE) else $error("bus driven idle");
  a_drive_cause:
    assert property ($rose(HOST_DATA_BUS_OE) |-> !IO_REQUEST_N) else $error("bus driven unasked");
  a_vector_lsb:
    assert property ($rose(HOST_DATA_BUS_OE) && !FIRST_CYCLE_N |-> !HOST_DATA_BUS_O[0])
      else $error("vector bit 0 set");
  a_strobe_ack:
    assert property ($rose(PORT_A_STROBE_N) && PORT_A_READY |-> ##[1:8] !PORT_A_READY)
      else $error("ready stuck after strobe");
  a_ready_late:
    assert property ($rose(PORT_A_READY) |-> IO_REQUEST_N && $past(IO_REQUEST_N, 2))
      else $error("ready rose during request");
  c_read: cover property ($rose(HOST_DATA_BUS_OE) && FIRST_CYCLE_N);
  c_ack: cover property ($rose(HOST_DATA_BUS_OE) && !FIRST_CYCLE_N);
  c_irq: cover property ($rose(INT_N_OE));
endmodule // dphs_chk
`default_nettype wire

// ---- testbench/dphs_periph.sv ----
// peripheral on one port: strobes data in or takes data out when ready
`default_nettype none
module dphs_periph (
  input wire logic clk,
  input wire logic rdy,
  input wire logic slow,
  input wire logic [7:0] dat,
  output logic stb_n,
  output logic [7:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // data offered only while strobing, inverted otherwise
  assign lines = stb_n ? ~dat : dat;
  // one strobe per ready, prompt or slow
  initial
  begin
    stb_n = 1'b1;
    forever
    begin
      @(posedge clk);
      if (rdy === 1'b1)
      begin
        repeat (slow ? 6 : 1) @(posedge clk);
        #1 stb_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 stb_n = 1'b1;
        repeat (8) @(posedge clk);
      end
    end
  end
endmodule // dphs_periph
`default_nettype wire

// ---- testbench/dphs_top_test.sv ----
// self-checking bench for the dual port handshake controller
`default_nettype none
module dphs_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, ce_n, io_request_n_n, rd_n, m1_n, sel, cd, ch_in, a_slow;
  logic [7:0] hd, ho, ao, aoe, bo, boe, a_per, b_per, q;
  logic hoe, ard, brd, ch_out, int_o, int_oe, port_a_strobe_n_n, port_b_strobe_n_n;
  int n_fail, compares, i;
  // host cycles: {op 0 write 1 read-check 2 read, port, control, data}
  localparam logic [11:0] ROWS [17] = '{
    12'h10f,
    12'h0a5,
    12'h4a5,
    12'h3cf,
    12'h3f0,
    12'h23c,
    12'h38f,
    12'h66c,
    12'h14f,
    12'h800,
    12'h45a,
    12'h18f,
    12'h800,
    12'h4a5,
    12'h1e0,
    12'h10f,
    12'h197};
  dphs_top dut (.CLK(clk), .RST_N(rst_n), .CE_N(ce_n), .IO_REQUEST_N(io_request_n_n), .RD_N(rd_n),
    .FIRST_CYCLE_N(m1_n), .PORT_SEL(sel), .CTRL_SEL(cd), .CHAIN_ENABLE_IN(ch_in),
    .PORT_A_STROBE_N(port_a_strobe_n_n), .PORT_B_STROBE_N(port_b_strobe_n_n), .HOST_DATA_BUS_I(hoe ? ho : hd),
    .PORT_A_LINES_I((aoe & ao) | (~aoe & a_per)), .PORT_B_LINES_I((boe & bo) | (~boe & b_per)),
    .HOST_DATA_BUS_O(ho), .HOST_DATA_BUS_OE(hoe), .PORT_A_LINES_O(ao), .PORT_A_LINES_OE(aoe),
    .PORT_B_LINES_O(bo), .PORT_B_LINES_OE(boe), .PORT_A_READY(ard), .PORT_B_READY(brd),
    .CHAIN_ENABLE_OUT(ch_out), .INT_N_O(int_o), .INT_N_OE(int_oe));
  dphs_periph per_a (.clk(clk), .rdy(ard), .slow(a_slow), .dat(8'h5a), .stb_n(port_a_strobe_n_n),
    .lines(a_per));
  dphs_periph per_b (.clk(clk), .rdy(brd), .slow(1'b1), .dat(8'h96), .stb_n(port_b_strobe_n_n),
    .lines(b_per));
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    summarize();
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic summarize();
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // pins {ce_n, rd_n, io_request_n_n, m1_n} held ten cycles, then a quiet gap
  task automatic xfer(input logic [3:0] p, input logic s, input logic c, input logic [7:0] d);
    @(posedge clk);
    #1 {ce_n, rd_n, io_request_n_n, m1_n} = p;
    sel = s;
    cd = c;
    hd = d;
    q = 8'hxx;
    repeat (10)
    begin
      @(posedge clk);
      if (hoe === 1'b1)
        q = ho;
    end
    #1 {ce_n, rd_n, io_request_n_n, m1_n} = 4'hf;
    repeat (30) @(posedge clk);
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    {ce_n, rd_n, io_request_n_n, m1_n} = 4'hf;
    {sel, cd, ch_in, a_slow, rst_n} = 5'h00;
    hd = 8'h00;
    n_fail = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1 ch_in = 1'b1;
    for (i = 0; i < 17; i++)
    begin
      xfer((ROWS[i][11:10] == 2'h0) ? 4'h5 : 4'h1, ROWS[i][9], ROWS[i][8], ROWS[i][7:0]);
      if (ROWS[i][11:10] == 2'h1)
        chk(q, ROWS[i][7:0]);
    end
    // port B control lines, quiet handshake and no request yet
    chk(boe, 8'h0f);
    chk(bo, 8'h3c);
    chk({7'h00, brd}, 8'h00);
    chk({6'h00, int_o, int_oe}, 8'h00);
    // slow peripheral takes the byte, interrupt then acknowledge
    #1 a_slow = 1'b1;
    xfer(4'h5, 1'b0, 1'b0, 8'h11);
    chk({6'h00, int_o, int_oe}, 8'h01);
    xfer(4'hc, 1'b0, 1'b0, 8'h00);
    chk(q, 8'he0);
    chk({7'h00, ch_out}, 8'h00);
    // first cycle alone returns to held reset until a control word
    xfer(4'he, 1'b0, 1'b0, 8'h00);
    chk(aoe, 8'h00);
    xfer(4'h5, 1'b0, 1'b0, 8'h77);
    chk(aoe, 8'h00);
    xfer(4'h5, 1'b0, 1'b1, 8'h0f);
    chk(aoe, 8'hff);
    chk(ao, 8'h00);
    summarize();
  end
endmodule // dphs_top_test
bind dphs_top dphs_chk chk (.*);
`default_nettype wire
